// ==== lcc_pkg.sv ====
// Constants, types and helpers for the line channel control registers.
// Assumes the serial command port delivers one command and one data byte.
`default_nettype none
package lcc_pkg;
   localparam logic [7:0] CMD_GAINS = 8'h50;
   localparam logic [7:0] CMD_GDAT = 8'h52;
   localparam logic [7:0] CMD_GDIR = 8'h54;
   localparam logic [7:0] CMD_SYS = 8'h56;
   localparam logic [7:0] CMD_TDM = 8'h5e;
   localparam logic [7:0] CMD_COF = 8'h60;
   localparam logic [7:0] MASK_GAINS = 8'h78;
   localparam logic [7:0] MASK_GDAT = 8'h03;
   localparam logic [7:0] MASK_GDIR = 8'h05;
   localparam logic [7:0] MASK_TDM = 8'h03;
   localparam logic [7:0] RST_GAINS = 8'h00;
   localparam logic [7:0] RST_GDAT = 8'h00;
   localparam logic [7:0] RST_GDIR = 8'h00;
   localparam logic [7:0] RST_TDM = 8'h00;
   localparam logic [7:0] RST_COF = 8'h00;
   localparam int TX_GAIN_BIT = 6;
   localparam int DRL_BIT = 3;
   localparam int REX_BIT = 7;
   localparam int METER_PULSE_ON_BIT = 6;
   localparam int ACT_BIT = 5;
   localparam int POL_BIT = 4;
   localparam int DIR_B_BIT = 2;
   localparam logic [1:0] FS_VALID_CNT = 2'h3;
   localparam int NSYNC = 12;
   // Resting pin levels: chip select and serial clock idle high.
   localparam logic [NSYNC-1:0] PIN_IDLE = 12'h003;

   typedef enum logic [3:0] {
      LS_DISC = 4'h0, LS_TIP_OPEN = 4'h1, LS_RING_OPEN = 4'h2,
      LS_ACT_LOW = 4'h3, LS_IDLE = 4'h4, LS_RING_BAL = 4'h7,
      LS_LOW_GAIN = 4'h8, LS_RING_UNB = 4'ha, LS_ACT_MID = 4'hb,
      LS_SHUT = 4'hf
   } line_state_e;
   localparam logic [3:0] RST_SS = 4'hf;

   typedef enum logic [1:0] {
      MP_CMD = 2'b00, MP_WR = 2'b01, MP_RD = 2'b10, MP_SKIP = 2'b11
   } mpi_st_e;

   typedef struct packed {
      logic tx_analog_gain;
      logic [1:0] rx_analog_level;
      logic rx_digital_loss;
      logic [3:0] line_state;
      logic ringing_status;
      logic meter_pulse_on;
      logic codec_activate;
      logic pcm_valid;
      logic feed_polarity;
      logic linear_code;
      logic mu_law;
      logic [5:0] filt_prog;
   } chan_out_s;

   function automatic logic is_ringing(input logic [3:0] s);
      return (s == LS_RING_BAL) || (s == LS_RING_UNB);
   endfunction

   function automatic logic cmd_known(input logic [7:0] c);
      logic [7:0] w;
      w = {c[7:1], 1'b0};
      return (w == CMD_GAINS) || (w == CMD_GDAT) || (w == CMD_GDIR) ||
         (w == CMD_SYS) || (w == CMD_TDM) || (w == CMD_COF);
   endfunction
endpackage
`default_nettype wire

// ==== line_channel_control_regs.sv ====
// Per-channel control registers for a two-channel line interface.
// Assumes a serial command port clocked by the host and an 8 kHz frame sync.
`timescale 1ns/1ps
`default_nettype none
module line_channel_control_regs (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic mpi_cs_n,
   input wire logic mpi_dclk,
   input wire logic mpi_din,
   output logic mpi_dout,
   output logic mpi_dout_oe_n,
   input wire logic [1:0] chan_en,
   input wire logic fs_pin,
   input wire logic [1:0] zero_cross,
   input wire logic [1:0] hook_det,
   input wire logic [1:0] auto_state_ctrl,
   input wire logic [7:0] meter_duration,
   input wire logic [1:0] gp_pin_a_i,
   output logic [1:0] gp_pin_a_o,
   output logic [1:0] gp_pin_a_oe_n,
   input wire logic [1:0] gp_pin_b_i,
   output logic [1:0] gp_pin_b_o,
   output logic [1:0] gp_pin_b_oe_n,
   input wire logic [1:0] sample_new,
   input wire logic [1:0] tbuf_has_data,
   output lcc_pkg::chan_out_s [1:0] chan_out,
   output logic [1:0] converter_data_flag,
   output logic test_src_chan,
   output logic pcm_use_wide_band
);
   import lcc_pkg::*;

   logic [NSYNC-1:0] raw, s1_q, s2_q, s3_q, flt_q, prv_q;
   logic cs_n, dclk_r, dclk_f, din, fs_r;
   logic [1:0] zx_r, hook, gpa, gpb;
   mpi_st_e mst_q;
   logic [2:0] bcnt_q;
   logic [7:0] sh_q, sh_n, rd_q, rd_val, wr_cmd_q, wr_dat_q;
   logic wr_stb_q, drive_q, dout_q, rsel;
   logic [7:0] gain_q [2];
   logic [7:0] gdat_q [2];
   logic [7:0] gdir_q [2];
   logic [7:0] cof_q [2];
   logic [3:0] ss_q [2];
   logic [3:0] app_q [2];
   logic [1:0] met_q, act_q, pol_q;
   logic [7:0] mcnt_q [2];
   logic [1:0] fscnt_q [2];
   logic [7:0] tdm_q;
   logic [1:0] flag_q;
   logic [1:0] wr_sys, auto_go;

   // Pins from outside pass three stages; a level counts when the last
   // two agree, so a single sampling glitch never looks like an edge.
   assign raw = {gp_pin_b_i, gp_pin_a_i, hook_det, zero_cross,
      fs_pin, mpi_din, mpi_dclk, mpi_cs_n};
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         flt_q <= PIN_IDLE;
         prv_q <= PIN_IDLE;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
         prv_q <= flt_q;
      end
   end
   assign cs_n = flt_q[0];
   assign dclk_r = flt_q[1] & ~prv_q[1];
   assign dclk_f = ~flt_q[1] & prv_q[1];
   assign din = flt_q[2];
   assign fs_r = flt_q[3] & ~prv_q[3];
   assign zx_r = flt_q[5:4] & ~prv_q[5:4];
   assign hook = flt_q[7:6];
   assign gpa = flt_q[9:8];
   assign gpb = flt_q[11:10];

   assign sh_n = {sh_q[6:0], din};
   // Reads come from the lowest enabled channel.
   assign rsel = ~chan_en[0];

   always_comb begin
      rd_val = 8'h00;
      case ({sh_n[7:1], 1'b0})
         CMD_GAINS: rd_val = gain_q[rsel];
         CMD_GDAT: rd_val = {6'h00, gpb[rsel], gpa[rsel]};
         CMD_GDIR: rd_val = gdir_q[rsel];
         CMD_SYS: rd_val = {is_ringing(app_q[rsel]), met_q[rsel],
            act_q[rsel], pol_q[rsel], ss_q[rsel]};
         CMD_TDM: rd_val = tdm_q;
         CMD_COF: rd_val = cof_q[rsel];
         default: rd_val = 8'h00;
      endcase
   end

   // Command framing: one command byte, then one data byte each way.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mst_q <= MP_CMD;
         bcnt_q <= 3'h0;
         sh_q <= 8'h00;
         wr_cmd_q <= 8'h00;
      end else if (cs_n) begin
         mst_q <= MP_CMD;
         bcnt_q <= 3'h0;
      end else if (dclk_r) begin
         sh_q <= sh_n;
         bcnt_q <= bcnt_q + 3'h1;
         if (bcnt_q == 3'h7) begin
            case (mst_q)
               MP_CMD: begin
                  wr_cmd_q <= sh_n;
                  if (!cmd_known(sh_n))
                     mst_q <= MP_SKIP;
                  else if (sh_n[0])
                     mst_q <= MP_RD;
                  else
                     mst_q <= MP_WR;
               end
               default: mst_q <= MP_SKIP;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wr_stb_q <= 1'b0;
         wr_dat_q <= 8'h00;
      end else begin
         wr_stb_q <= !cs_n && dclk_r && bcnt_q == 3'h7 && mst_q == MP_WR;
         if (!cs_n && dclk_r && bcnt_q == 3'h7 && mst_q == MP_WR)
            wr_dat_q <= sh_n;
      end
   end

   // Read data leaves on falling clock edges so the host samples it
   // half a bit later on the rising edge.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rd_q <= 8'h00;
         dout_q <= 1'b0;
         drive_q <= 1'b0;
      end else if (cs_n) begin
         drive_q <= 1'b0;
      end else if (dclk_r && bcnt_q == 3'h7 && mst_q == MP_CMD) begin
         rd_q <= rd_val;
         drive_q <= cmd_known(sh_n) & sh_n[0];
      end else if (dclk_f && mst_q == MP_RD) begin
         dout_q <= rd_q[7];
         rd_q <= {rd_q[6:0], 1'b0};
      end else if (mst_q == MP_SKIP && dclk_f) begin
         drive_q <= 1'b0;
      end
   end
   assign mpi_dout = dout_q;
   assign mpi_dout_oe_n = ~drive_q;

   // Plain configuration registers; reserved bits are masked off.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++) begin
            gain_q[i] <= RST_GAINS;
            gdat_q[i] <= RST_GDAT;
            gdir_q[i] <= RST_GDIR;
            cof_q[i] <= RST_COF;
         end
         tdm_q <= RST_TDM;
      end else if (wr_stb_q) begin
         for (int i = 0; i < 2; i++) begin
            if (chan_en[i]) begin
               if (wr_cmd_q == CMD_GAINS)
                  gain_q[i] <= wr_dat_q & MASK_GAINS;
               if (wr_cmd_q == CMD_GDAT)
                  gdat_q[i] <= wr_dat_q & MASK_GDAT;
               if (wr_cmd_q == CMD_GDIR)
                  gdir_q[i] <= wr_dat_q & MASK_GDIR;
               if (wr_cmd_q == CMD_COF)
                  cof_q[i] <= wr_dat_q;
            end
         end
         if (wr_cmd_q == CMD_TDM && chan_en != 2'h0)
            tdm_q <= wr_dat_q & MASK_TDM;
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         wr_sys[i] = wr_stb_q && chan_en[i] && wr_cmd_q == CMD_SYS;
         auto_go[i] = auto_state_ctrl[i] && hook[i] &&
            (app_q[i] == LS_IDLE || is_ringing(app_q[i]) ||
            app_q[i] == LS_TIP_OPEN || app_q[i] == LS_RING_OPEN);
      end
   end

   // System state. A host write beats an automatic move in the same
   // cycle, and its metering, activate and polarity bits are taken
   // as written whatever the state field says.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++) begin
            ss_q[i] <= RST_SS;
            mcnt_q[i] <= 8'h00;
         end
         met_q <= 2'h0;
         act_q <= 2'h0;
         pol_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_sys[i]) begin
               ss_q[i] <= wr_dat_q[3:0];
               act_q[i] <= wr_dat_q[ACT_BIT];
               pol_q[i] <= wr_dat_q[POL_BIT];
               met_q[i] <= wr_dat_q[METER_PULSE_ON_BIT];
               mcnt_q[i] <= meter_duration;
            end else begin
               if (auto_go[i] && ss_q[i] == app_q[i]) begin
                  ss_q[i] <= LS_ACT_LOW;
                  act_q[i] <= 1'b1;
               end
               if (met_q[i] && fs_r) begin
                  if (mcnt_q[i] <= 8'h01)
                     met_q[i] <= 1'b0;
                  else
                     mcnt_q[i] <= mcnt_q[i] - 8'h01;
               end
            end
         end
      end
   end

   // Leaving ringing waits for a zero cross to limit line transients.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++)
            app_q[i] <= RST_SS;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ss_q[i] != app_q[i] && (!is_ringing(app_q[i]) ||
               is_ringing(ss_q[i]) || zx_r[i]))
               app_q[i] <= ss_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++)
            fscnt_q[i] <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!act_q[i])
               fscnt_q[i] <= 2'h0;
            else if (fs_r && fscnt_q[i] != FS_VALID_CNT)
               fscnt_q[i] <= fscnt_q[i] + 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         flag_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (tdm_q[0])
               flag_q[i] <= (tdm_q[1] == i[0]) & tbuf_has_data[i];
            else
               flag_q[i] <= sample_new[i];
         end
      end
   end
   assign converter_data_flag = flag_q;
   assign test_src_chan = tdm_q[0] & tdm_q[1];
   assign pcm_use_wide_band = tdm_q[0];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         chan_out[i].tx_analog_gain = gain_q[i][TX_GAIN_BIT];
         chan_out[i].rx_analog_level = gain_q[i][5:4];
         chan_out[i].rx_digital_loss = gain_q[i][DRL_BIT];
         chan_out[i].line_state = app_q[i];
         chan_out[i].ringing_status = is_ringing(app_q[i]);
         chan_out[i].meter_pulse_on = met_q[i];
         chan_out[i].codec_activate = act_q[i];
         chan_out[i].pcm_valid = act_q[i] && fscnt_q[i] == FS_VALID_CNT;
         chan_out[i].feed_polarity = pol_q[i];
         chan_out[i].linear_code = cof_q[i][7];
         chan_out[i].mu_law = cof_q[i][6];
         chan_out[i].filt_prog = cof_q[i][5:0];
         gp_pin_a_o[i] = gdat_q[i][0];
         gp_pin_b_o[i] = gdat_q[i][1];
         gp_pin_a_oe_n[i] = ~gdir_q[i][0];
         gp_pin_b_oe_n[i] = ~gdir_q[i][DIR_B_BIT];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence sys_wr0;
      wr_stb_q && chan_en[0] && wr_cmd_q == CMD_SYS;
   endsequence

   sequence gains_wr0;
      wr_stb_q && chan_en[0] && wr_cmd_q == CMD_GAINS;
   endsequence

   sequence auto_move0;
      auto_go[0] && !wr_sys[0] && ss_q[0] == app_q[0];
   endsequence

   AST_RX_LEVEL: assert property (
      wr_stb_q && chan_en[0] && wr_cmd_q == CMD_GAINS |=>
      chan_out[0].rx_analog_level == $past(wr_dat_q[5:4]))
      else $error("rx level not taken from write");
   AST_DIR_OE: assert property (
      wr_stb_q && chan_en[0] && wr_cmd_q == CMD_GDIR |=>
      gp_pin_b_oe_n[0] == !$past(wr_dat_q[2]))
      else $error("pin b enable wrong");
   AST_METER_END: assert property (
      met_q[0] && fs_r && mcnt_q[0] <= 8'h01 && !wr_sys[0] |=> !met_q[0])
      else $error("meter pulse not ended");
   AST_PCM_WAIT: assert property (
      $rose(act_q[0]) |-> !chan_out[0].pcm_valid [*3])
      else $error("pcm valid too early");
   AST_RING_HOLD: assert property (
      is_ringing(app_q[0]) && !is_ringing(ss_q[0]) && !zx_r[0] |=>
      chan_out[0].ringing_status)
      else $error("ringing exit did not wait");
   AST_STATE_RB: assert property (
      sys_wr0 |=> ss_q[0] == $past(wr_dat_q[3:0]))
      else $error("state not read back");
   AST_PRIO: assert property (
      sys_wr0 |=> act_q[0] == $past(wr_dat_q[ACT_BIT]) &&
      pol_q[0] == $past(wr_dat_q[POL_BIT]))
      else $error("non-state bits lost");
   AST_TSRC: assert property (
      !tdm_q[0] |-> !test_src_chan)
      else $error("channel select active outside test mode");
   AST_DAT: assert property (
      !tdm_q[0] && sample_new[0] |=> converter_data_flag[0])
      else $error("data flag missed sample");
   AST_TX_GAIN: assert property (
      gains_wr0 |=> chan_out[0].tx_analog_gain ==
      $past(wr_dat_q[TX_GAIN_BIT]))
      else $error("tx gain not taken from write");
   AST_RX_LOSS: assert property (
      gains_wr0 |=> chan_out[0].rx_digital_loss ==
      $past(wr_dat_q[DRL_BIT]))
      else $error("digital loss not taken from write");
   AST_AUTO_MOVE: assert property (
      auto_move0 |=> ss_q[0] == LS_ACT_LOW && act_q[0])
      else $error("automatic move to active missed");
   AST_FLAG_SEL: assert property (
      tdm_q[0] && !tdm_q[1] |=> !converter_data_flag[1])
      else $error("data flag names the unselected channel");
   AST_FLAG_BUF: assert property (
      tdm_q[0] && !tdm_q[1] && tbuf_has_data[0] |=>
      converter_data_flag[0])
      else $error("data flag missed buffered data");
endmodule // line_channel_control_regs
`default_nettype wire

// ==== mpi_host_model.sv ====
// Host model that issues command and data bytes on the serial port.
// Assumes the block samples its serial pins on sys_clk at 25 MHz.
`timescale 1ns/1ps
`default_nettype none
module mpi_host_model (
   input wire logic sys_clk,
   output logic cs_n,
   output logic dclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe_n
);
   // Each serial clock phase spans 8 cycles so the block's sampler keeps up.
   localparam int HALF = 8;
   logic drove;
   initial begin
      cs_n = 1'b1;
      dclk = 1'b1;
      din = 1'b0;
      drove = 1'b0;
   end
   task automatic xfer(input logic [7:0] c, input logic [7:0] w,
                       output logic [7:0] r);
      logic [15:0] sh;
      sh = {c, w};
      r = 8'h00;
      drove = 1'b0;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (HALF) @(posedge sys_clk);
      for (int i = 15; i >= 0; i--) begin
         dclk <= 1'b0;
         din <= sh[i];
         repeat (HALF) @(posedge sys_clk);
         if (i < 8) begin
            // A released line reads as the inverse of its last value.
            r = {r[6:0], dout_oe_n ? ~dout : dout};
         end
         if (!dout_oe_n) begin
            drove = 1'b1;
         end
         dclk <= 1'b1;
         repeat (HALF) @(posedge sys_clk);
      end
      cs_n <= 1'b1;
      // A released data line must not look like a held value.
      din <= ~din;
      repeat (2 * HALF) @(posedge sys_clk);
   endtask
endmodule // mpi_host_model
`default_nettype wire

// ==== test_line_channel_control_regs.sv ====
// Self-checking bench for the line channel control registers.
// Assumes mpi_host_model drives the serial port and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_line_channel_control_regs;
   import lcc_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic cs_n, dclk, din, dout, dout_oe_n;
   logic [1:0] chan_en = 2'b11;
   logic fs_pin = 1'b0;
   logic [1:0] zc = 2'b00;
   logic [1:0] hook = 2'b00;
   logic [1:0] auto_sc = 2'b00;
   logic [7:0] mdur = 8'h02;
   logic [1:0] a_ext = 2'b00;
   logic [1:0] b_ext = 2'b00;
   logic [1:0] a_o, a_oe_n, b_o, b_oe_n, a_lvl, b_lvl;
   logic [1:0] smp = 2'b00;
   logic [1:0] tbuf = 2'b00;
   chan_out_s [1:0] co;
   logic [1:0] dflag;
   logic src, wide;
   logic [7:0] rr;
   int n_mismatch = 0;
   int compares = 0;
   logic [7:0] rcmd [6] = '{CMD_GAINS, CMD_GDAT, CMD_GDIR, CMD_SYS,
      CMD_TDM, CMD_COF};
   logic [7:0] rmsk [6] = '{MASK_GAINS, MASK_GDAT, MASK_GDIR, 8'hff,
      MASK_TDM, 8'hff};
   logic [7:0] rrst [6] = '{RST_GAINS, RST_GDAT, RST_GDIR, {4'h0, RST_SS},
      RST_TDM, RST_COF};
   logic [3:0] sts [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hf};
   // The pin level follows whichever party drives it.
   assign a_lvl = (a_oe_n & a_ext) | (~a_oe_n & a_o);
   assign b_lvl = (b_oe_n & b_ext) | (~b_oe_n & b_o);
   always #20 sys_clk = ~sys_clk;

   line_channel_control_regs u_line_channel_control_regs (
      .sys_clk(sys_clk), .rstn(rstn), .mpi_cs_n(cs_n), .mpi_dclk(dclk),
      .mpi_din(din), .mpi_dout(dout), .mpi_dout_oe_n(dout_oe_n),
      .chan_en(chan_en), .fs_pin(fs_pin), .zero_cross(zc),
      .hook_det(hook), .auto_state_ctrl(auto_sc), .meter_duration(mdur),
      .gp_pin_a_i(a_lvl), .gp_pin_a_o(a_o), .gp_pin_a_oe_n(a_oe_n),
      .gp_pin_b_i(b_lvl), .gp_pin_b_o(b_o), .gp_pin_b_oe_n(b_oe_n),
      .sample_new(smp), .tbuf_has_data(tbuf), .chan_out(co),
      .converter_data_flag(dflag), .test_src_chan(src),
      .pcm_use_wide_band(wide));
   mpi_host_model u_mpi_host_model (
      .sys_clk(sys_clk), .cs_n(cs_n), .dclk(dclk), .din(din),
      .dout(dout), .dout_oe_n(dout_oe_n));

   task automatic end_of_test;
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      u_mpi_host_model.xfer(c, d, r);
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] m,
                     input logic [7:0] exp);
      logic [7:0] r;
      u_mpi_host_model.xfer(c | 8'h01, 8'h00, r);
      cmp8(r & m, exp);
   endtask
   task automatic tick(input logic [2:0] m);
      @(posedge sys_clk);
      {fs_pin, zc} <= m;
      repeat (6) @(posedge sys_clk);
      {fs_pin, zc} <= 3'h0;
      repeat (8) @(posedge sys_clk);
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      for (int i = 0; i < 6; i++) begin
         rd(rcmd[i], rmsk[i], rrst[i]);
      end
      cmp8({4'h0, a_oe_n, b_oe_n}, 8'h0f);
      wr(CMD_GAINS, 8'h58);
      rd(CMD_GAINS, MASK_GAINS, 8'h58);
      cmp8({4'h0, co[1].tx_analog_gain, co[1].rx_analog_level,
         co[1].rx_digital_loss}, 8'h0b);
      wr(CMD_GAINS, 8'h28);
      cmp8({4'h0, co[0].tx_analog_gain, co[0].rx_analog_level,
         co[0].rx_digital_loss}, 8'h05);
      a_ext <= 2'b11;
      repeat (8) @(posedge sys_clk);
      rd(CMD_GDAT, MASK_GDAT, 8'h01);
      wr(CMD_GDIR, 8'h05);
      wr(CMD_GDAT, 8'h02);
      cmp8({a_oe_n, b_oe_n, a_o, b_o}, 8'h03);
      rd(CMD_GDAT, MASK_GDAT, 8'h02);
      wr(CMD_GDIR, 8'h04);
      rd(CMD_GDAT, MASK_GDAT, 8'h03);
      for (int i = 0; i < 8; i++) begin
         wr(CMD_SYS, {4'h0, sts[i]});
         rd(CMD_SYS, 8'hff, {4'h0, sts[i]});
         cmp8(8'(co[0].line_state), {4'h0, sts[i]});
      end
      wr(CMD_SYS, 8'h84);
      rd(CMD_SYS, 8'hff, 8'h04);
      wr(CMD_SYS, 8'h13);
      cmp8(8'(co[0].feed_polarity), 8'h01);
      wr(CMD_SYS, 8'h07);
      rd(CMD_SYS, 8'hff, 8'h87);
      wr(CMD_SYS, 8'h03);
      rd(CMD_SYS, 8'hff, 8'h83);
      cmp8({co[0].line_state, 3'h0, co[0].ringing_status}, 8'h71);
      tick(3'b011);
      cmp8({co[1].line_state, 3'h0, co[1].ringing_status}, 8'h30);
      wr(CMD_SYS, 8'h23);
      tick(3'b100);
      tick(3'b100);
      cmp8(8'(co[0].pcm_valid), 8'h00);
      tick(3'b100);
      cmp8(8'(co[0].pcm_valid), 8'h01);
      wr(CMD_SYS, 8'h43);
      rd(CMD_SYS, 8'hff, 8'h43);
      tick(3'b100);
      cmp8(8'(co[0].meter_pulse_on), 8'h01);
      tick(3'b100);
      rd(CMD_SYS, 8'hff, 8'h03);
      wr(CMD_SYS, 8'h04);
      auto_sc <= 2'b01;
      hook <= 2'b11;
      repeat (12) @(posedge sys_clk);
      cmp8({co[0].line_state, co[1].line_state}, 8'h34);
      cmp8(8'(co[0].codec_activate), 8'h01);
      auto_sc <= 2'b00;
      hook <= 2'b00;
      smp <= 2'b11;
      repeat (4) @(posedge sys_clk);
      cmp8(8'(dflag), 8'h03);
      wr(CMD_TDM, 8'h03);
      rd(CMD_TDM, MASK_TDM, 8'h03);
      cmp8({6'h0, src, wide}, 8'h03);
      cmp8(8'(dflag), 8'h00);
      tbuf <= 2'b10;
      repeat (4) @(posedge sys_clk);
      cmp8(8'(dflag), 8'h02);
      wr(CMD_TDM, 8'h01);
      cmp8({4'h0, src, wide, dflag}, 8'h04);
      tbuf <= 2'b01;
      repeat (4) @(posedge sys_clk);
      cmp8(8'(dflag), 8'h01);
      wr(CMD_TDM, 8'h02);
      cmp8({4'h0, src, wide, dflag}, 8'h03);
      wr(CMD_COF, 8'hc5);
      rd(CMD_COF, 8'hff, 8'hc5);
      cmp8({co[0].linear_code, co[0].mu_law, co[0].filt_prog}, 8'hc5);
      wr(CMD_COF, 8'h3a);
      chan_en <= 2'b10;
      wr(CMD_COF, 8'h00);
      cmp8({co[0].linear_code, co[0].mu_law, co[0].filt_prog}, 8'h3a);
      rd(CMD_COF, 8'hff, 8'h00);
      chan_en <= 2'b11;
      u_mpi_host_model.xfer(8'h59, 8'h00, rr);
      cmp8(8'(u_mpi_host_model.drove), 8'h00);
      end_of_test();
   end
endmodule // test_line_channel_control_regs
`default_nettype wire
